/* src/pbt_exec.sv */
/*
  Port output and block transfer execution unit with its data FIFO.
  Assumes the decoder presents one instruction with start_in while idle,
  and that peripherals and memory hold read data while ready is high.
*/
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Data FIFO, depth must be a power of two
module pbt_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic      [W-1:0] out_data_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  // Extra pointer bit tells full from empty
  assign in_ready_out  = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
  assign out_valid_out = (wp_q != rp_q);
  assign out_data_out  = mem_q[rp_q[AW-1:0]];
  // Storage has no reset, only pointers do
  always_ff @(posedge clk_in) begin
    if (in_valid_in && in_ready_out) begin
      mem_q[wp_q[AW-1:0]] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (in_valid_in && in_ready_out) wp_q <= wp_q + 1'b1;
      if (out_valid_out && out_ready_in) rp_q <= rp_q + 1'b1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
module pbt_exec #(
  parameter int DEPTH = 32
) (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        start_in,
  input  wire logic        prefix_in,
  input  wire logic [7:0]  opcode_in,
  input  wire logic [7:0]  imm_in,
  input  wire logic [15:0] pc_in,
  input  wire logic        reg_wr_in,
  input  wire logic [2:0]  reg_sel_in,
  input  wire logic [7:0]  reg_data_in,
  input  wire logic        int_pend_in,
  input  wire logic [7:0]  io_rdata_in,
  input  wire logic        io_ready_in,
  input  wire logic [7:0]  mem_rdata_in,
  input  wire logic        mem_ready_in,
  output logic             busy_out,
  output logic             done_out,
  output logic             illegal_out,
  output logic [15:0]      addr_out,
  output logic [7:0]       data_out,
  output logic             io_rd_out,
  output logic             io_wr_out,
  output logic             mem_rd_out,
  output logic             mem_wr_out,
  output logic             rfsh_out,
  output logic             int_ack_out,
  output logic [15:0]      pc_out,
  output logic [7:0]       count_out,
  output logic [7:0]       port_index_out,
  output logic [15:0]      pointer_out,
  output logic             zero_flag_out,
  output logic             subtract_flag_out,
  output logic             flag_wr_out
);
  pbt_pkg::pbt_state_t state_q;
  logic        busy_q, done_q, ill_q, rfsh_q, rcnt_q, iack_q;
  logic        blk_q, out_q, down_q, rpt_q, imm_q;
  logic [2:0]  rsel_q;
  logic [7:0]  imm_port_q, data_q;
  logic [15:0] instr_pc_q, pc_q, addr_q;
  logic        io_rd_q, io_wr_q, mem_rd_q, mem_wr_q;
  logic [4:0]  tcnt_q;
  logic [7:0]  rf_q [8];
  logic        z_q, n_q, fw_q;

  // Decode of the offered instruction
  logic dec_blk, dec_reg, dec_imm, legal;
  assign dec_blk = prefix_in && ((opcode_in & pbt_pkg::BLK_MASK) == pbt_pkg::BLK_BASE);
  assign dec_reg = prefix_in && ((opcode_in & pbt_pkg::REG_MASK) == pbt_pkg::REG_BASE);
  assign dec_imm = !prefix_in && (opcode_in == pbt_pkg::OP_OUT_IMM);
  assign legal   = dec_blk || dec_reg || dec_imm;

  // Working values; 8-bit wrap makes a zero count run 256 times
  logic [7:0]  cnt, cnt_dec;
  logic [15:0] ptr, ptr_nx;
  assign cnt     = rf_q[pbt_pkg::R_CNT];
  assign cnt_dec = cnt - 8'h01;
  assign ptr     = {rf_q[pbt_pkg::R_PTRH], rf_q[pbt_pkg::R_PTRL]};
  assign ptr_nx  = down_q ? ptr - 16'h0001 : ptr + 16'h0001;

  // FIFO hookup: source pushes, sink launch pops
  logic fifo_ir, fifo_ov, src_ack, push, launch, snk_done;
  logic [7:0] push_data, fifo_data;
  assign src_ack   = !blk_q || (io_rd_q && io_ready_in) || (mem_rd_q && mem_ready_in);
  assign push      = (state_q == pbt_pkg::S_SRC) && src_ack && fifo_ir;
  assign launch    = (state_q == pbt_pkg::S_SNK) && !io_wr_q && !mem_wr_q && fifo_ov;
  assign snk_done  = (io_wr_q && io_ready_in) || (mem_wr_q && mem_ready_in);
  assign push_data = !blk_q ? (imm_q ? rf_q[pbt_pkg::R_ACC] : rf_q[rsel_q])
                   : (out_q ? mem_rdata_in : io_rdata_in);

  pbt_fifo #(.W(8), .D(DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ir),
    .in_data_in    (push_data),
    .out_valid_out (fifo_ov),
    .out_ready_in  (launch),
    .out_data_out  (fifo_data)
  );

  // Instruction length and end of transfer
  logic [4:0] tlen;
  logic       fin, again;
  assign again = blk_q && rpt_q && (cnt_dec != 8'h00);
  assign tlen  = blk_q ? (again ? pbt_pkg::T_BLK_RPT - pbt_pkg::T_RFSH : pbt_pkg::T_BLK)
               : (imm_q ? pbt_pkg::T_OUT_IMM : pbt_pkg::T_OUT_REG);
  assign fin   = (state_q == pbt_pkg::S_PAD) && (tcnt_q >= tlen - 5'h01);

  ////////////////////////////////////////////////////////////////////
  // Sequencer; refresh reuses the ISS/IDLE exit via rfsh_q
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_q <= pbt_pkg::S_IDLE;
      busy_q  <= 1'b0;
    end else begin
      unique case (state_q)
        pbt_pkg::S_IDLE: begin
          if (start_in && legal && !rfsh_q) begin
            state_q <= pbt_pkg::S_ISS;
            busy_q  <= 1'b1;
          end else if (rfsh_q && rcnt_q) begin
            if (int_pend_in) begin
              busy_q <= 1'b0;
            end else begin
              state_q <= pbt_pkg::S_ISS;
            end
          end
        end
        pbt_pkg::S_ISS: state_q <= pbt_pkg::S_SRC;
        pbt_pkg::S_SRC: if (push) state_q <= pbt_pkg::S_SNK;
        pbt_pkg::S_SNK: if (snk_done) state_q <= pbt_pkg::S_PAD;
        pbt_pkg::S_PAD: begin
          if (fin) begin
            state_q <= pbt_pkg::S_IDLE;
            busy_q  <= again;
          end
        end
        default: state_q <= pbt_pkg::S_IDLE;
      endcase
    end
  end

  // Latch of the accepted instruction
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      {blk_q, out_q, down_q, rpt_q, imm_q} <= '0;
      rsel_q     <= 3'h0;
      imm_port_q <= 8'h00;
      instr_pc_q <= 16'h0000;
    end else if (state_q == pbt_pkg::S_IDLE && start_in && legal && !busy_q) begin
      blk_q      <= dec_blk;
      out_q      <= dec_blk && opcode_in[pbt_pkg::BIT_OUT];
      down_q     <= opcode_in[pbt_pkg::BIT_DOWN];
      rpt_q      <= dec_blk && opcode_in[pbt_pkg::BIT_RPT];
      imm_q      <= dec_imm;
      rsel_q     <= opcode_in[pbt_pkg::RSEL_LSB +: 3];
      imm_port_q <= imm_in;
      instr_pc_q <= pc_in;
    end
  end

  // Refresh pair after each byte of a repeat but the last; interrupt window follows
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rfsh_q <= 1'b0;
      rcnt_q <= 1'b0;
      iack_q <= 1'b0;
    end else begin
      iack_q <= rfsh_q && rcnt_q && int_pend_in;
      if (fin && again) begin
        rfsh_q <= 1'b1;
        rcnt_q <= 1'b0;
      end else if (rfsh_q) begin
        rfsh_q <= !rcnt_q;
        rcnt_q <= 1'b1;
      end
    end
  end

  // T-state counter, restarted at each issue, saturates on long stalls
  always_ff @(posedge clk_in) begin
    if (!resetn_in || state_q == pbt_pkg::S_ISS) begin
      tcnt_q <= 5'h00;
    end else if (tcnt_q != 5'h1F) begin
      tcnt_q <= tcnt_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Address, strobes and data; one shared address bus
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      addr_q <= 16'h0000;
      data_q <= 8'h00;
      {io_rd_q, io_wr_q, mem_rd_q, mem_wr_q} <= '0;
    end else begin
      if (state_q == pbt_pkg::S_ISS && blk_q) begin
        if (out_q) begin
          mem_rd_q <= 1'b1;
          addr_q   <= ptr;
        end else begin
          io_rd_q <= 1'b1;
          addr_q  <= {cnt, rf_q[pbt_pkg::R_PORT]};
        end
      end
      if (push) begin
        io_rd_q  <= 1'b0;
        mem_rd_q <= 1'b0;
      end
      if (launch) begin
        data_q <= fifo_data;
        if (blk_q && !out_q) begin
          mem_wr_q <= 1'b1;
          addr_q   <= ptr;
        end else begin
          io_wr_q <= 1'b1;
          if (blk_q) addr_q <= {cnt_dec, rf_q[pbt_pkg::R_PORT]};
          else if (imm_q) addr_q <= {rf_q[pbt_pkg::R_ACC], imm_port_q};
          else addr_q <= {cnt, rf_q[pbt_pkg::R_PORT]};
        end
      end
      if (snk_done) begin
        io_wr_q  <= 1'b0;
        mem_wr_q <= 1'b0;
      end
    end
  end

  // Register file: software writes while idle, block ends update it
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 8; i++) rf_q[i] <= 8'h00;
    end else if (fin && blk_q) begin
      rf_q[pbt_pkg::R_CNT]  <= cnt_dec;
      rf_q[pbt_pkg::R_PTRH] <= ptr_nx[15:8];
      rf_q[pbt_pkg::R_PTRL] <= ptr_nx[7:0];
    end else if (reg_wr_in && !busy_q && reg_sel_in != pbt_pkg::R_NONE) begin
      rf_q[reg_sel_in] <= reg_data_in;
    end
  end

  // Flags, program counter and completion; carry is never touched here
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      {z_q, n_q, fw_q, done_q, ill_q} <= '0;
      pc_q <= 16'h0000;
    end else begin
      fw_q   <= fin && blk_q;
      done_q <= fin && !again;
      ill_q  <= state_q == pbt_pkg::S_IDLE && start_in && !legal && !busy_q;
      if (fin && blk_q) begin
        z_q <= (cnt_dec == 8'h00);
        n_q <= 1'b1;
      end
      if (state_q == pbt_pkg::S_IDLE && start_in && legal && !busy_q) begin
        pc_q <= pc_in + pbt_pkg::PC_STEP;
      end else if (fin) begin
        pc_q <= again ? pc_q - pbt_pkg::PC_STEP : instr_pc_q + pbt_pkg::PC_STEP;
      end else if (rfsh_q && rcnt_q && !int_pend_in) begin
        pc_q <= instr_pc_q + pbt_pkg::PC_STEP;
      end
    end
  end

  // Outputs straight from flops
  assign busy_out          = busy_q;
  assign done_out          = done_q;
  assign illegal_out       = ill_q;
  assign addr_out          = addr_q;
  assign data_out          = data_q;
  assign io_rd_out         = io_rd_q;
  assign io_wr_out         = io_wr_q;
  assign mem_rd_out        = mem_rd_q;
  assign mem_wr_out        = mem_wr_q;
  assign rfsh_out          = rfsh_q;
  assign int_ack_out       = iack_q;
  assign pc_out            = pc_q;
  assign count_out         = rf_q[pbt_pkg::R_CNT];
  assign port_index_out    = rf_q[pbt_pkg::R_PORT];
  assign pointer_out       = ptr;
  assign zero_flag_out     = z_q;
  assign subtract_flag_out = n_q;
  assign flag_wr_out       = fw_q;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_in_addr;
    io_rd_out |-> addr_out == {count_out, port_index_out};
  endproperty
  a_in_addr: assert property (p_in_addr) else $error("input port address wrong");
  property p_store;
    (mem_wr_out && !out_q) |-> addr_out == pointer_out && io_wr_out == 1'b0;
  endproperty
  a_store: assert property (p_store) else $error("store address wrong");
  property p_down;
    (fin && blk_q && down_q) |=> pointer_out == $past(ptr) - 16'h0001
      && count_out == $past(cnt) - 8'h01;
  endproperty
  a_down: assert property (p_down) else $error("down step wrong");
  property p_loop;
    (fin && again) |=> rfsh_out [*2] ##1 (state_q == pbt_pkg::S_ISS || int_ack_out);
  endproperty
  a_loop: assert property (p_loop) else $error("repeat loop wrong");
  property p_end;
    (fin && blk_q && rpt_q && !again) |=> done_out && zero_flag_out
      && subtract_flag_out && pc_out == instr_pc_q + pbt_pkg::PC_STEP;
  endproperty
  a_end: assert property (p_end) else $error("repeat end wrong");
  property p_flags;
    (fin && blk_q && !rpt_q) |=> flag_wr_out && subtract_flag_out
      && zero_flag_out == (count_out == 8'h00);
  endproperty
  a_flags: assert property (p_flags) else $error("step flags wrong");
  property p_imm;
    (io_wr_out && imm_q) |-> addr_out == {rf_q[pbt_pkg::R_ACC], imm_port_q}
      && data_out == rf_q[pbt_pkg::R_ACC];
  endproperty
  a_imm: assert property (p_imm) else $error("immediate write wrong");
  property p_reg;
    (io_wr_out && !blk_q && !imm_q) |-> addr_out == {count_out, port_index_out}
      && data_out == rf_q[rsel_q];
  endproperty
  a_reg: assert property (p_reg) else $error("register write wrong");
  property p_out_addr;
    (io_wr_out && blk_q) |-> addr_out[15:8] == count_out - 8'h01;
  endproperty
  a_out_addr: assert property (p_out_addr) else $error("output count wrong");
  property p_up;
    (fin && blk_q && !down_q) |=> pointer_out == $past(ptr) + 16'h0001;
  endproperty
  a_up: assert property (p_up) else $error("up step wrong");
  property p_irq;
    int_ack_out |-> pc_out == instr_pc_q && !busy_out;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt pc wrong");
endmodule
`default_nettype wire

/* src/pbt_pkg.sv */
/*
  Constants, opcodes, register indices and states of the port I/O and
  block-transfer execution unit.
  Assumes one clock cycle per processor T-state.
*/
`default_nettype none
package pbt_pkg;
  // Opcodes: block group matches (op & BLK_MASK) == BLK_BASE
  localparam logic [7:0] PFX_ED     = 8'hED;
  localparam logic [7:0] OP_OUT_IMM = 8'hD3;
  localparam logic [7:0] BLK_MASK   = 8'hE6;
  localparam logic [7:0] BLK_BASE   = 8'hA2;
  localparam logic [7:0] REG_MASK   = 8'hC7;
  localparam logic [7:0] REG_BASE   = 8'h41;
  localparam int         BIT_OUT    = 0;
  localparam int         BIT_DOWN   = 3;
  localparam int         BIT_RPT    = 4;
  localparam int         RSEL_LSB   = 3;
  // Register file indices, 6 is the undefined slot and reads zero
  localparam logic [2:0] R_CNT  = 3'h0;
  localparam logic [2:0] R_PORT = 3'h1;
  localparam logic [2:0] R_PTRH = 3'h4;
  localparam logic [2:0] R_PTRL = 3'h5;
  localparam logic [2:0] R_NONE = 3'h6;
  localparam logic [2:0] R_ACC  = 3'h7;
  // T-state lengths, one cycle each
  localparam logic [4:0] T_OUT_IMM = 5'h0B;
  localparam logic [4:0] T_OUT_REG = 5'h0C;
  localparam logic [4:0] T_BLK     = 5'h10;
  localparam logic [4:0] T_BLK_RPT = 5'h15;
  localparam logic [4:0] T_RFSH    = 5'h02;
  localparam logic [15:0] PC_STEP  = 16'h0002;
  typedef enum logic [4:0] {
    S_IDLE = 5'b0_0001,
    S_ISS  = 5'b0_0010,
    S_SRC  = 5'b0_0100,
    S_SNK  = 5'b0_1000,
    S_PAD  = 5'b1_0000
  } pbt_state_t;
  localparam pbt_state_t S_RFSH_UNUSED = S_IDLE;
endpackage
`default_nettype wire

/* tb/pbt_far_model.sv */
/*
  Memory and peripheral model for the block-transfer unit.
  Assumes every strobe is held until its ready is seen; ready lasts one cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module pbt_far_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  data_in,
  input  wire logic        io_rd_in,
  input  wire logic        io_wr_in,
  input  wire logic        mem_rd_in,
  input  wire logic        mem_wr_in,
  input  wire logic [1:0]  wait_in,
  output logic [7:0]       io_rdata_out = 8'h00,
  output logic             io_ready_out = 1'b0,
  output logic [7:0]       mem_rdata_out = 8'h00,
  output logic             mem_ready_out = 1'b0
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  in_q [$];
  logic [23:0] wr_q [$];
  logic [15:0] rd_q [$];
  logic [1:0]  io_cnt_q = 2'h0;
  logic [1:0]  mem_cnt_q = 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // Peripheral: answers after wait_in cycles; idle data toggles, never holds
  // Plain always blocks: the bench also loads memory and the queues directly
  always @(posedge clk_in) begin
    if ((io_rd_in || io_wr_in) && !io_ready_out && io_cnt_q == wait_in) begin
      io_ready_out <= 1'b1;
      io_cnt_q     <= 2'h0;
      if (io_rd_in) begin
        io_rdata_out <= in_q.pop_front();
        rd_q.push_back(addr_in);
      end else begin
        wr_q.push_back({addr_in, data_in});
      end
    end else begin
      io_ready_out <= 1'b0;
      io_rdata_out <= ~io_rdata_out;
      io_cnt_q     <= (io_rd_in || io_wr_in) ? io_cnt_q + 2'h1 : 2'h0;
    end
  end

  // Memory: same pacing as the peripheral
  always @(posedge clk_in) begin
    if ((mem_rd_in || mem_wr_in) && !mem_ready_out && mem_cnt_q == wait_in) begin
      mem_ready_out <= 1'b1;
      mem_cnt_q     <= 2'h0;
      if (mem_rd_in) begin
        mem_rdata_out <= mem[addr_in];
      end else begin
        mem[addr_in] <= data_in;
      end
    end else begin
      mem_ready_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      mem_cnt_q     <= (mem_rd_in || mem_wr_in) ? mem_cnt_q + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

/* tb/tb_pbt_exec.sv */
/*
  Self-checking bench of the port write and block transfer unit.
  Assumes the far-side model answers every strobe; one cycle per T-state.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_pbt_exec;
  logic clk_in = 1'b0, resetn_in = 1'b0, start_in = 1'b0, prefix_in = 1'b0;
  logic [7:0] opcode_in = 8'h00, imm_in = 8'h00, reg_data_in = 8'h00;
  logic [15:0] pc_in = 16'h0000;
  logic reg_wr_in = 1'b0, int_pend_in = 1'b0;
  logic [2:0] reg_sel_in = 3'h0;
  logic [1:0] slow = 2'h0;
  logic [7:0] io_rdata, mem_rdata, data_out, count_out, port_index_out;
  logic io_ready, mem_ready, busy_out, done_out, illegal_out, io_rd_out, io_wr_out;
  logic mem_rd_out, mem_wr_out, rfsh_out, int_ack_out, zero_flag_out, subtract_flag_out;
  logic flag_wr_out, ack, ill;
  logic [15:0] addr_out, pc_out, pointer_out;
  int errors = 0, n_tests = 0, cyc, n_rfsh = 0;

  pbt_exec #(.DEPTH(32)) dut (.clk_in(clk_in), .resetn_in(resetn_in), .start_in(start_in),
    .prefix_in(prefix_in), .opcode_in(opcode_in), .imm_in(imm_in), .pc_in(pc_in),
    .reg_wr_in(reg_wr_in), .reg_sel_in(reg_sel_in), .reg_data_in(reg_data_in),
    .int_pend_in(int_pend_in), .io_rdata_in(io_rdata), .io_ready_in(io_ready),
    .mem_rdata_in(mem_rdata), .mem_ready_in(mem_ready), .busy_out(busy_out),
    .done_out(done_out), .illegal_out(illegal_out), .addr_out(addr_out), .data_out(data_out),
    .io_rd_out(io_rd_out), .io_wr_out(io_wr_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .rfsh_out(rfsh_out), .int_ack_out(int_ack_out), .pc_out(pc_out),
    .count_out(count_out), .port_index_out(port_index_out), .pointer_out(pointer_out),
    .zero_flag_out(zero_flag_out), .subtract_flag_out(subtract_flag_out),
    .flag_wr_out(flag_wr_out));
  pbt_far_model far (.clk_in(clk_in), .addr_in(addr_out), .data_in(data_out),
    .io_rd_in(io_rd_out), .io_wr_in(io_wr_out), .mem_rd_in(mem_rd_out),
    .mem_wr_in(mem_wr_out), .wait_in(slow), .io_rdata_out(io_rdata), .io_ready_out(io_ready),
    .mem_rdata_out(mem_rdata), .mem_ready_out(mem_ready));

  ////////////////////////////////////////////////////////////////////////
  // Clock, refresh counter and shared tasks
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (rfsh_out === 1'b1) n_rfsh++;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic setr(input logic [2:0] sel, input logic [7:0] val);
    @(posedge clk_in);
    reg_wr_in   <= 1'b1;
    reg_sel_in  <= sel;
    reg_data_in <= val;
    @(posedge clk_in);
    reg_wr_in   <= 1'b0;
  endtask

  // Counter, port, pointer; clears the far-side logs
  task automatic prep(input logic [7:0] cnt, input logic [7:0] port, input logic [15:0] ptr);
    setr(3'h0, cnt);
    setr(3'h1, port);
    setr(3'h4, ptr[15:8]);
    setr(3'h5, ptr[7:0]);
    far.wr_q.delete();
    far.rd_q.delete();
    n_rfsh = 0;
  endtask

  // Issue one instruction and wait, bounded, for its end, interrupt exit or refusal
  task automatic run(input logic pfx, input logic [7:0] op, input logic [7:0] imm,
                     input logic [15:0] pc);
    cyc = 0;
    @(posedge clk_in);
    start_in  <= 1'b1;
    prefix_in <= pfx;
    opcode_in <= op;
    imm_in    <= imm;
    pc_in     <= pc;
    @(posedge clk_in);
    start_in  <= 1'b0;
    #1;
    while (done_out !== 1'b1 && int_ack_out !== 1'b1 && illegal_out !== 1'b1 && cyc < 20000) begin
      @(posedge clk_in);
      #1;
      cyc++;
    end
    ack = int_ack_out;
    ill = illegal_out;
    // A hang counts as one mismatch; the watchdog ends the run if more follow
    if (cyc >= 20000) begin
      errors++;
      $display("mismatch run_end expected done seen none");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_writes();
    setr(3'h7, 8'h5A);
    far.wr_q.delete();
    run(1'b0, 8'hD3, 8'h37, 16'h0100);
    chk("imm_write", 16'h5A37, far.wr_q[0][23:8]);
    chk("imm_data", 16'h005A, {8'h00, far.wr_q[0][7:0]});
    chk("imm_len", 16'h0001, {15'h0, cyc >= 11});
    chk("imm_fw", 16'h0000, {15'h0, flag_wr_out});
    for (int i = 0; i < 8; i++) setr(3'(i), 8'h20 + 8'(i));
    // The undefined field must put zero on the bus, not a stale register
    for (int r = 0; r < 8; r++) begin
      far.wr_q.delete();
      run(1'b1, 8'h41 | 8'(r << 3), 8'h00, 16'h0200);
      chk("reg_addr", 16'h2021, far.wr_q[0][23:8]);
      chk("reg_data", (r == 6) ? 16'h0 : 16'h0020 + 16'(r), {8'h00, far.wr_q[0][7:0]});
      chk("reg_len", 16'h0001, {15'h0, cyc >= 12});
      chk("reg_zero", 16'h0000, {15'h0, zero_flag_out});
      chk("reg_fw", 16'h0000, {15'h0, flag_wr_out});
    end
    run(1'b1, 8'h00, 8'h00, 16'h0300);
    chk("illegal", 16'h0001, {15'h0, ill});
  endtask

  task automatic t_steps();
    prep(8'h10, 8'h07, 16'h1000);
    far.in_q.push_back(8'h7B);
    run(1'b1, 8'hAA, 8'h00, 16'h0400);
    chk("in_addr", 16'h1007, far.rd_q[0]);
    chk("in_mem", 16'h007B, {8'h00, far.mem[16'h1000]});
    chk("in_count", 16'h000F, {8'h00, count_out});
    chk("in_ptr", 16'h0FFF, pointer_out);
    chk("in_flags", 16'h0001, {14'h0, zero_flag_out, subtract_flag_out});
    chk("in_fw", 16'h0001, {15'h0, flag_wr_out});
    chk("in_port", 16'h0007, {8'h00, port_index_out});
    prep(8'h01, 8'h07, 16'h2000);
    far.mem[16'h2000] = 8'h59;
    run(1'b1, 8'hA3, 8'h00, 16'h0500);
    chk("out_write", 16'h0007, far.wr_q[0][23:8]);
    chk("out_data", 16'h0059, {8'h00, far.wr_q[0][7:0]});
    chk("out_ptr", 16'h2001, pointer_out);
    chk("out_flags", 16'h0003, {14'h0, zero_flag_out, subtract_flag_out});
  endtask

  // Slow far side, then an interrupt between iterations and a resume
  task automatic t_repeats();
    slow = 2'h2;
    prep(8'h03, 8'h07, 16'h1000);
    far.in_q = '{8'h51, 8'hA9, 8'h03};
    run(1'b1, 8'hB2, 8'h00, 16'h0600);
    chk("up_mem", 16'hA903, {far.mem[16'h1001], far.mem[16'h1002]});
    chk("up_ptr", 16'h1003, pointer_out);
    chk("up_flags", 16'h0003, {6'h0, count_out, zero_flag_out, subtract_flag_out});
    chk("up_pc", 16'h0602, pc_out);
    chk("up_rfsh", 16'h0004, 16'(n_rfsh));
    slow = 2'h0;
    prep(8'h03, 8'h07, 16'h1000);
    far.in_q = '{8'h51, 8'hA9, 8'h03};
    int_pend_in <= 1'b1;
    run(1'b1, 8'hBA, 8'h00, 16'h0700);
    chk("int_ack", 16'h0001, {15'h0, ack});
    chk("int_busy", 16'h0000, {15'h0, busy_out});
    chk("int_pc", 16'h0700, pc_out);
    @(posedge clk_in);
    int_pend_in <= 1'b0;
    chk("int_state", 16'h0FFF, pointer_out);
    chk("int_count", 16'h0002, {8'h00, count_out});
    run(1'b1, 8'hBA, 8'h00, 16'h0700);
    chk("dn_mem", 16'h03A9, {far.mem[16'h0FFE], far.mem[16'h0FFF]});
    chk("dn_ptr", 16'h0FFD, pointer_out);
    chk("dn_end", 16'h0001, {15'h0, done_out});
  endtask

  task automatic t_full_page();
    prep(8'h00, 8'h07, 16'h3000);
    for (int i = 0; i < 256; i++) far.mem[16'h3000 + 16'(i)] = 8'(i);
    run(1'b1, 8'hB3, 8'h00, 16'h0800);
    chk("pg_bytes", 16'd256, 16'(far.wr_q.size()));
    chk("pg_first", 16'hFF07, far.wr_q[0][23:8]);
    chk("pg_last", 16'h0007, far.wr_q[255][23:8]);
    chk("pg_data", 16'h00FF, {8'h00, far.wr_q[255][7:0]});
    chk("pg_ptr", 16'h3100, pointer_out);
    chk("pg_rfsh", 16'd510, 16'(n_rfsh));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict, watchdog and main sequence
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog: 50k cycles, several times the expected length of all scenarios
  initial begin
    #500_000;
    errors++;
    $display("mismatch watchdog expected finish seen timeout");
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    #1;
    chk("rst_state", 16'h0000, {busy_out, done_out, count_out, 6'h0});
    t_writes();
    t_steps();
    t_repeats();
    t_full_page();
    end_sim();
  end
endmodule
`default_nettype wire
